//--- mrs_params.svh
// offsets, field positions, reset values and widths of the result bank
`ifndef MRS_PARAMS_SVH
`define MRS_PARAMS_SVH
`define MRS_OFS_FLAGS_A 8'h00
`define MRS_OFS_FLAGS_B 8'h01
`define MRS_OFS_INT_SUP_LO 8'h03
`define MRS_OFS_EXT_LO 8'h04
`define MRS_OFS_SUP_HI 8'h06
`define MRS_OFS_INT_HI 8'h07
`define MRS_BIT_INT_HIGH 0
`define MRS_BIT_INT_LOW 1
`define MRS_BIT_EXT_HIGH 2
`define MRS_BIT_EXT_LOW 3
`define MRS_BIT_EXT_FAULT 4
`define MRS_BIT_SUP 4
`define MRS_RST_REG 8'h00
`define MRS_RST_RESULT 10'h000
`define MRS_EXT_UPPER_DEFAULT 8'hff
`define MRS_EXT_LOWER_DEFAULT 8'h00
`define MRS_RESULT_W 10
`define MRS_LIMIT_W 8
`endif

//--- mrs_pkg.sv
// types shared by the monitor result bank
package mrs_pkg;
  typedef struct packed {
    logic [9:0] intTemp;
    logic [9:0] extTemp;
    logic [9:0] supply;
  } mrs_results_t;
  typedef struct packed {
    logic [7:0] tempUpperLimitInt;
    logic [7:0] tempLowerLimitInt;
    logic [7:0] tempUpperLimitExt;
    logic [7:0] tempLowerLimitExt;
    logic [7:0] supplyUpperLimit;
    logic [7:0] supplyLowerLimit;
  } mrs_limits_t;
  typedef enum logic [1:0] {
    MRS_UNLOCKED,
    MRS_LOCKED
  } mrs_lock_t;
endpackage

//--- mrs_limit_cmp.sv
// compares one 10-bit result against an 8-bit upper and lower limit
`timescale 1ns/1ps
module mrs_limit_cmp #(
  parameter int RESULT_W = 10,
  parameter bit SIGNED_CMP = 1'b1
) (
  input wire logic [RESULT_W-1:0] result,
  input wire logic [7:0] upperLimit,
  input wire logic [7:0] lowerLimit,
  output logic aboveUpper,
  output logic atOrBelowLower
);
  logic [RESULT_W-1:0] upExt;
  logic [RESULT_W-1:0] loExt;
  // limits carry the upper 8 result bits; scale to result width
  assign upExt = {upperLimit, {(RESULT_W-8){1'b1}}};
  assign loExt = {lowerLimit, {(RESULT_W-8){1'b0}}};
  always_comb begin
    if (SIGNED_CMP) begin
      aboveUpper = $signed(result) > $signed(upExt);
      atOrBelowLower = $signed(result) <= $signed(loExt);
    end else begin
      aboveUpper = result > upExt;
      atOrBelowLower = result <= loExt;
    end
  end
endmodule // mrs_limit_cmp

//--- mrs_result_hold.sv
// result holder that stops updating while locked
`timescale 1ns/1ps
module mrs_result_hold #(
  parameter int W = 10
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic hold,
  input wire logic [W-1:0] newValue,
  output logic [W-1:0] value
);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= '0;
    end else if (load && !hold) begin
      value <= newValue;
    end
  end
endmodule // mrs_result_hold

//--- mrs_result_regs.sv
// Functional notes
// [RQ1] status registers clear on read only when all reported conditions are gone
// [RQ2] software reset clears both status registers unconditionally
// [RQ3] flag A bit 0: internal temperature above its upper limit
// [RQ4] flag A bit 1: internal temperature at or below its lower limit
// [RQ5] flag A bit 2: external temperature above upper limit, default minus one
// [RQ6] flag A bit 3: external temperature at or below lower limit, default zero
// [RQ7] flag A bit 4: external sensor open or short; bits 7..5 zero
// [RQ8] flag B bit 4: supply above its upper limit; other bits zero
// [RQ9] flag B bit 4 also set when supply at or below lower limit
// [RQ10] any set flag drives the interrupt output active
// [RQ11] shared low register: internal temperature bits 1..0 at positions 1..0
// [RQ12] shared low register: supply bits 1..0 at positions 3..2
// [RQ13] external low register: external bits 1..0 at 1..0, rest zero
// [RQ14] supply high register holds bits 9..2, loaded with measurement at start
// [RQ15] internal high register holds two's complement bits 9..2
// [RQ16] other registers read zero after power-up
// [RQ17] reading a low register first freezes its linked high registers
// [RQ18] reading any frozen high register releases all of them
// [RQ19] reading a high register first freezes nothing
// [RQ20] unused bits read zero; writes have no effect
`timescale 1ns/1ps
`include "mrs_params.svh"
module mrs_result_regs
  import mrs_pkg::*;
#(
  parameter int RESULT_W = `MRS_RESULT_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic softReset,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic intActiveHigh,
  input wire logic resultValid,
  input wire mrs_results_t results,
  input wire mrs_limits_t limits,
  input wire logic extSensorFault,
  output logic [7:0] regRdData,
  output logic regRdValid,
  output logic intOut
);
  logic [7:0] flagsA;
  logic [7:0] flagsB;
  logic [7:0] next_flagsA;
  logic [7:0] next_flagsB;
  logic [7:0] condA;
  logic [7:0] condB;
  logic [1:0] intLo;
  logic [1:0] extLo;
  logic [1:0] supLo;
  logic [RESULT_W-1:0] supHold;
  logic [RESULT_W-1:0] intHold;
  logic [RESULT_W-1:0] extHold;
  logic intHi;
  logic intLow;
  logic extHi;
  logic extLow;
  logic supHi;
  logic supLow;
  logic [4:0] liveCond;
  logic [4:0] heldCond;
  logic [4:0] limitCond;
  logic highLocked;
  logic supSeeded;
  mrs_lock_t lockState;
  logic rdFlagsA;
  logic rdFlagsB;
  logic rdIntSupLo;
  logic rdHigh;
  logic unusedWr;

  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  assign rdFlagsA = regRead && isAddr(regAddr, `MRS_OFS_FLAGS_A);
  assign rdFlagsB = regRead && isAddr(regAddr, `MRS_OFS_FLAGS_B);
  assign rdIntSupLo = regRead && isAddr(regAddr, `MRS_OFS_INT_SUP_LO);
  assign rdHigh = regRead && (isAddr(regAddr, `MRS_OFS_SUP_HI) ||
                              isAddr(regAddr, `MRS_OFS_INT_HI));
  // host writes land nowhere
  assign unusedWr = regWrite & (|regWrData); // [RQ20]

  // limit comparisons: temperatures signed, supply unsigned
  mrs_limit_cmp #(.RESULT_W(RESULT_W), .SIGNED_CMP(1'b1)) u_cmpInt (
    .result(results.intTemp),
    .upperLimit(limits.tempUpperLimitInt),
    .lowerLimit(limits.tempLowerLimitInt),
    .aboveUpper(intHi),
    .atOrBelowLower(intLow)
  );
  mrs_limit_cmp #(.RESULT_W(RESULT_W), .SIGNED_CMP(1'b1)) u_cmpExt (
    .result(results.extTemp),
    .upperLimit(limits.tempUpperLimitExt),
    .lowerLimit(limits.tempLowerLimitExt),
    .aboveUpper(extHi),
    .atOrBelowLower(extLow)
  );
  mrs_limit_cmp #(.RESULT_W(RESULT_W), .SIGNED_CMP(1'b0)) u_cmpSup (
    .result(results.supply),
    .upperLimit(limits.supplyUpperLimit),
    .lowerLimit(limits.supplyLowerLimit),
    .aboveUpper(supHi),
    .atOrBelowLower(supLow)
  );

  // verdict of the conversion on the inputs now
  assign liveCond = {supHi | supLow, extLow, extHi, intLow, intHi}; // [RQ9]

  // verdict of the last conversion stands until the next one or a soft reset
  // so a read cannot clear a flag whose result is still out of limit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      heldCond <= '0;
    end else if (softReset) begin
      heldCond <= '0; // [RQ2]
    end else if (resultValid) begin
      heldCond <= liveCond; // [RQ1]
    end
  end
  assign limitCond = resultValid ? liveCond : heldCond; // [RQ1]

  always_comb begin
    condA = '0;
    condB = '0;
    condA[`MRS_BIT_INT_HIGH] = limitCond[0]; // [RQ3]
    condA[`MRS_BIT_INT_LOW] = limitCond[1]; // [RQ4]
    condA[`MRS_BIT_EXT_HIGH] = limitCond[2]; // [RQ5]
    condA[`MRS_BIT_EXT_LOW] = limitCond[3]; // [RQ6]
    condB[`MRS_BIT_SUP] = limitCond[4]; // [RQ8] [RQ9]
    condA[`MRS_BIT_EXT_FAULT] = extSensorFault; // [RQ7]
  end

  // flags stick; a read clears a register only when none of its own conditions is present
  always_comb begin
    next_flagsA = flagsA;
    next_flagsB = flagsB;
    if (softReset) begin
      next_flagsA = `MRS_RST_REG; // [RQ2]
      next_flagsB = `MRS_RST_REG; // [RQ2]
    end else begin
      if (rdFlagsA && condA == '0) begin
        next_flagsA = `MRS_RST_REG; // [RQ1]
      end
      if (rdFlagsB && condB == '0) begin
        next_flagsB = `MRS_RST_REG; // [RQ1]
      end
      next_flagsA = next_flagsA | condA;
      next_flagsB = next_flagsB | condB;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flagsA <= `MRS_RST_REG; // [RQ16]
      flagsB <= `MRS_RST_REG; // [RQ16]
    end else begin
      flagsA <= next_flagsA & 8'h1f; // [RQ7] [RQ20]
      flagsB <= next_flagsB & 8'h10; // [RQ8] [RQ20]
    end
  end

  // interrupt output follows any set flag in chosen polarity
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      intOut <= 1'b0;
    end else begin
      intOut <= ((|next_flagsA) | (|next_flagsB)) ~^ intActiveHigh; // [RQ10]
    end
  end

  // lock of the high registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockState <= MRS_UNLOCKED;
    end else begin
      case (lockState)
        MRS_UNLOCKED: begin
          if (rdIntSupLo) begin
            lockState <= MRS_LOCKED; // [RQ17]
          end
        end
        MRS_LOCKED: begin
          if (rdHigh) begin
            lockState <= MRS_UNLOCKED; // [RQ18]
          end
        end
        default: lockState <= MRS_UNLOCKED;
      endcase
    end
  end
  // a high read while unlocked leaves the lock alone
  assign highLocked = (lockState == MRS_LOCKED); // [RQ19]

  // supply holder is loaded once after reset even if no valid yet
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      supSeeded <= 1'b0;
    end else begin
      supSeeded <= 1'b1;
    end
  end

  mrs_result_hold #(.W(RESULT_W)) u_holdSup (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(resultValid | !supSeeded), // [RQ14]
    .hold(highLocked), // [RQ17]
    .newValue(results.supply),
    .value(supHold)
  );
  mrs_result_hold #(.W(RESULT_W)) u_holdInt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(resultValid),
    .hold(highLocked), // [RQ17]
    .newValue(results.intTemp),
    .value(intHold)
  );
  mrs_result_hold #(.W(RESULT_W)) u_holdExt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(resultValid),
    .hold(1'b0),
    .newValue(results.extTemp),
    .value(extHold)
  );

  // low bits follow the latest conversion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      intLo <= '0;
      supLo <= '0;
      extLo <= '0;
    end else if (resultValid) begin
      intLo <= results.intTemp[1:0];
      supLo <= results.supply[1:0];
      extLo <= results.extTemp[1:0];
    end
  end

  // read data register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= `MRS_RST_REG;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        case (regAddr)
          `MRS_OFS_FLAGS_A: regRdData <= flagsA;
          `MRS_OFS_FLAGS_B: regRdData <= flagsB;
          `MRS_OFS_INT_SUP_LO: regRdData <= {4'h0, supLo, intLo}; // [RQ11] [RQ12]
          `MRS_OFS_EXT_LO: regRdData <= {6'h00, extLo}; // [RQ13]
          `MRS_OFS_SUP_HI: regRdData <= supHold[RESULT_W-1:2]; // [RQ14]
          `MRS_OFS_INT_HI: regRdData <= intHold[RESULT_W-1:2]; // [RQ15]
          default: regRdData <= 8'h00; // [RQ20]
        endcase
      end
    end
  end
endmodule // mrs_result_regs

//--- mrs_result_regs_chk.sv
// port assertions for the monitor result bank
`timescale 1ns/1ps
module mrs_result_regs_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic softReset,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic intActiveHigh,
  input wire logic resultValid,
  input wire logic extSensorFault,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic intOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_unmapped;
    regRead && regAddr == 8'h02 |=> regRdValid && regRdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad gap read");
  property p_flags_a;
    regRead && regAddr == 8'h00 |=> regRdData[7:5] == 3'h0;
  endproperty
  a_flags_a: assert property (p_flags_a) else $error("flags a unused");
  property p_flags_b;
    regRead && regAddr == 8'h01 |=> {regRdData[7:5], regRdData[3:0]} == 7'h00;
  endproperty
  a_flags_b: assert property (p_flags_b) else $error("flags b unused");
  property p_shared_lo;
    regRead && regAddr == 8'h03 |=> regRdData[7:4] == 4'h0;
  endproperty
  a_shared_lo: assert property (p_shared_lo) else $error("shared lo");
  property p_ext_lo;
    regRead && regAddr == 8'h04 |=> regRdData[7:2] == 6'h00;
  endproperty
  a_ext_lo: assert property (p_ext_lo) else $error("ext lo unused");
  property p_fault;
    extSensorFault && intActiveHigh && !softReset |=> intOut;
  endproperty
  a_fault: assert property (p_fault) else $error("fault no irq");
  property p_soft;
    softReset && !extSensorFault && !resultValid |=>
      intOut == !$past(intActiveHigh);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset");
  property p_write;
    regWrite && !regRead |=> $stable(regRdData);
  endproperty
  a_write: assert property (p_write) else $error("write effect");
endmodule // mrs_result_regs_chk

bind mrs_result_regs mrs_result_regs_chk i_chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .softReset(softReset), .regRead(regRead),
  .regWrite(regWrite), .regAddr(regAddr), .intActiveHigh(intActiveHigh),
  .resultValid(resultValid), .extSensorFault(extSensorFault),
  .regRdData(regRdData), .regRdValid(regRdValid), .intOut(intOut));

//--- mrs_meas_model.sv
// measurement core model: results, limits, conversion pulse, fault
`timescale 1ns/1ps
module mrs_meas_model
  import mrs_pkg::*;
(
  input wire logic sys_clk,
  output mrs_results_t results,
  output mrs_limits_t limits,
  output logic resultValid,
  output logic extSensorFault
);
  initial begin
    results = '{10'h000, 10'h000, 10'h2a5};
    limits = '{8'h64, 8'hc9, 8'hff, 8'h00, 8'hc7, 8'h62};
    resultValid = 1'b0;
    extSensorFault = 1'b0;
  end
  // one conversion: new results with a one-cycle valid pulse
  task automatic conv(input logic [9:0] i, e, s);
    @(posedge sys_clk) #1;
    results = '{i, e, s};
    resultValid = 1'b1;
    @(posedge sys_clk) #1;
    resultValid = 1'b0;
  endtask
  // new external limits, as the host would program them
  task automatic set_ext_limits(input logic [7:0] up, lo);
    limits.tempUpperLimitExt = up;
    limits.tempLowerLimitExt = lo;
  endtask
  // external sensor fault level
  task automatic set_fault(input logic f);
    extSensorFault = f;
  endtask
endmodule // mrs_meas_model

//--- tb_top.sv
// self-checking bench for the monitor result bank
`timescale 1ns/1ps
module tb_top
  import mrs_pkg::*;
;
  logic sys_clk, rst_n, softReset, regRead, regWrite, intActiveHigh;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regRdValid, intOut, resultValid, extSensorFault;
  mrs_results_t results;
  mrs_limits_t limits;
  int bad_count = 0;
  int n_checks = 0;
  logic [7:0] adr [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07};
  logic [7:0] ini [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha9, 8'h00};
  mrs_meas_model i_meas (.sys_clk(sys_clk), .results(results),
    .limits(limits), .resultValid(resultValid),
    .extSensorFault(extSensorFault));
  mrs_result_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .softReset(softReset), .regRead(regRead), .regWrite(regWrite),
    .regAddr(regAddr), .regWrData(regWrData),
    .intActiveHigh(intActiveHigh), .resultValid(resultValid),
    .results(results), .limits(limits), .extSensorFault(extSensorFault),
    .regRdData(regRdData), .regRdValid(regRdValid), .intOut(intOut));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_bit(input logic got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: bit %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk_data(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: data %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge sys_clk) #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge sys_clk) #1;
    regRead = 1'b0;
    chk_bit(regRdValid, 1'b1);
    chk_data(regRdData, exp);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    bad_count++;
    print_verdict();
  end
  initial begin
    {rst_n, softReset, regRead, regWrite} = 4'h0;
    {regAddr, regWrData} = 16'h0000;
    intActiveHigh = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    for (int k = 0; k < 7; k++) rd(adr[k], ini[k]);
    i_meas.conv(10'h194, 10'h001, 10'h2a5);
    i_meas.conv(10'h324, 10'h3fe, 10'h188);
    i_meas.set_ext_limits(8'h64, 8'hc9);
    i_meas.conv(10'h0c6, 10'h3fe, 10'h2a5);
    chk_bit(intOut, 1'b1);
    rd(8'h00, 8'h0f);
    rd(8'h01, 8'h10);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    i_meas.set_fault(1'b1);
    rd(8'h00, 8'h10);
    rd(8'h00, 8'h10);
    intActiveHigh = 1'b0;
    @(posedge sys_clk) #1;
    chk_bit(intOut, 1'b0);
    intActiveHigh = 1'b1;
    i_meas.set_fault(1'b0);
    rd(8'h00, 8'h10);
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h02);
    rd(8'h03, 8'h06);
    i_meas.conv(10'h100, 10'h3fe, 10'h004);
    rd(8'h03, 8'h00);
    rd(8'h07, 8'h31);
    i_meas.conv(10'h100, 10'h3fe, 10'h004);
    rd(8'h06, 8'h01);
    i_meas.conv(10'h0c6, 10'h3fe, 10'h2a5);
    rd(8'h07, 8'h31);
    regWrite = 1'b1;
    regAddr = 8'h07;
    regWrData = 8'hff;
    @(posedge sys_clk) #1;
    regWrite = 1'b0;
    rd(8'h07, 8'h31);
    rd(8'h01, 8'h10);
    chk_bit(intOut, 1'b0);
    i_meas.conv(10'h0c6, 10'h3fe, 10'h3c0);
    chk_bit(intOut, 1'b1);
    rd(8'h01, 8'h10);
    rd(8'h01, 8'h10);
    softReset = 1'b1;
    @(posedge sys_clk) #1;
    softReset = 1'b0;
    chk_bit(intOut, 1'b0);
    rd(8'h01, 8'h00);
    print_verdict();
  end
endmodule // tb_top
